// ### hdl/link_control_upper_fields.v
// link control upper fields: control bits 7..11, bandwidth status and
// the interrupt built from them, reached over axi4-lite
// assumes link-side event pulses synchronous to sys_clk_i
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`include "link_ctl_consts.vh"
module link_control_upper_fields #(
	parameter AW = 4,
	parameter IS_UPSTREAM = 0
) (
	// clock and reset
	input wire sys_clk_i,
	input wire nrst_i,
	input wire clk_en_i,
	// axi write address
	input wire [AW-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// axi write data and response
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	// axi read
	input wire [AW-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	// capability and link events
	input wire bandwidth_notify_capable_i,
	input wire retrain_done_i,
	input wire dl_down_i,
	input wire reliability_change_i,
	input wire autonomous_change_i,
	// physical layer controls
	output wire extra_sync_ordered_sets_o,
	output wire autonomous_width_disable_o,
	output wire reliability_width_allow_o,
	// interrupts
	output wire link_irq_o,
	output wire irq_o
);
	wire wr_stb;
	wire [AW-1:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [AW-1:0] rd_addr;
	reg [31:0] rd_data;
	reg rd_err;
	reg wr_err;
	reg extra_sync_ordered_sets_reg;
	reg bwm_en_reg;
	reg abw_en_reg;
	reg [1:0] irq_mask_reg;
	wire bwm_sts;
	wire abw_sts;
	wire bwm_irq_sts;
	wire abw_irq_sts;
	wire en_allowed;
	wire [15:0] ctl_view;
	wire [15:0] sts_view;
	wire [1:0] irq_view;

	function lane_hit;
		input [3:0] strb;
		input integer bitpos;
		begin
			lane_hit = strb[bitpos / 8];
		end
	endfunction

	function w1c;
		input stb;
		input [AW-1:0] addr;
		input [AW-1:0] target;
		input [31:0] data;
		input [3:0] strb;
		input integer bitpos;
		begin
			w1c = stb && (addr == target) && data[bitpos] &&
				lane_hit(strb, bitpos);
		end
	endfunction

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	lc_axil_slave #(.AW(AW)) u_bus (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clk_en_i(clk_en_i),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_stb_o(wr_stb),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wr_strb_o(wr_strb),
		.wr_err_i(wr_err),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data),
		.rd_err_i(rd_err)
	);

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	// enables gated by capability and port role
	assign en_allowed = bandwidth_notify_capable_i && (IS_UPSTREAM == 0);

	always @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			extra_sync_ordered_sets_reg <= `LC_ZERO1;
			bwm_en_reg <= `LC_ZERO1;
			abw_en_reg <= `LC_ZERO1;
			irq_mask_reg <= `LC_ZERO2;
		end else if (clk_en_i) begin
			if (wr_stb && wr_addr == `LC_ADDR_CTL) begin
				if (lane_hit(wr_strb, `LC_BIT_EXTRA_SYNC_ORDERED_SETS))
					extra_sync_ordered_sets_reg <= wr_data[`LC_BIT_EXTRA_SYNC_ORDERED_SETS];
				if (lane_hit(wr_strb, `LC_BIT_BWM_EN))
					bwm_en_reg <= wr_data[`LC_BIT_BWM_EN];
				if (lane_hit(wr_strb, `LC_BIT_ABW_EN))
					abw_en_reg <= wr_data[`LC_BIT_ABW_EN];
			end
			if (wr_stb && wr_addr == `LC_ADDR_IRQ_MASK &&
				lane_hit(wr_strb, 0))
				irq_mask_reg <= wr_data[1:0];
		end
	end

	assign extra_sync_ordered_sets_o = extra_sync_ordered_sets_reg;
	// width disable tied off, not fed to reconfiguration
	assign autonomous_width_disable_o = `LC_ZERO1;
	// autonomous narrowing only on reliability trouble
	assign reliability_width_allow_o = reliability_change_i;

	assign ctl_view = {4'h0,
		abw_en_reg && en_allowed,
		bwm_en_reg && en_allowed,
		`LC_ZERO1,
		`LC_ZERO1,
		extra_sync_ordered_sets_reg,
		7'h00};

	// ----------------------------------------
	// bandwidth status
	// ----------------------------------------
	// set on retrain done or reliability change sans dl_down
	lc_sticky_bit u_bwm (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clk_en_i(clk_en_i),
		.enable_i(en_allowed),
		.set_i((retrain_done_i || reliability_change_i) && !dl_down_i),
		.clear_i(w1c(wr_stb, wr_addr, `LC_ADDR_STS, wr_data, wr_strb,
			`LC_BIT_BWM_STS)),
		.flag_o(bwm_sts)
	);

	lc_sticky_bit u_abw (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clk_en_i(clk_en_i),
		.enable_i(en_allowed),
		.set_i(autonomous_change_i && !dl_down_i),
		.clear_i(w1c(wr_stb, wr_addr, `LC_ADDR_STS, wr_data, wr_strb,
			`LC_BIT_ABW_STS)),
		.flag_o(abw_sts)
	);

	assign sts_view = {abw_sts, bwm_sts, 14'h0000};

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	// request only while status and enable both set
	assign link_irq_o = (bwm_sts && bwm_en_reg && en_allowed) ||
		(abw_sts && abw_en_reg && en_allowed);

	// sticky copies so software sees which event fired via mask path
	lc_sticky_bit u_irq_bwm (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clk_en_i(clk_en_i),
		.enable_i(1'b1),
		.set_i(bwm_sts && bwm_en_reg && en_allowed),
		.clear_i(w1c(wr_stb, wr_addr, `LC_ADDR_IRQ_STS, wr_data, wr_strb,
			`LC_IRQ_BWM)),
		.flag_o(bwm_irq_sts)
	);

	lc_sticky_bit u_irq_abw (
		.sys_clk_i(sys_clk_i),
		.nrst_i(nrst_i),
		.clk_en_i(clk_en_i),
		.enable_i(1'b1),
		.set_i(abw_sts && abw_en_reg && en_allowed),
		.clear_i(w1c(wr_stb, wr_addr, `LC_ADDR_IRQ_STS, wr_data, wr_strb,
			`LC_IRQ_ABW)),
		.flag_o(abw_irq_sts)
	);

	assign irq_view = {abw_irq_sts, bwm_irq_sts};
	assign irq_o = |(irq_view & irq_mask_reg);

	// ----------------------------------------
	// read mux and decode
	// ----------------------------------------
	always @* begin
		rd_data = `LC_ZERO32;
		rd_err = `LC_ZERO1;
		case (rd_addr)
		`LC_ADDR_CTL: rd_data = {16'h0000, ctl_view};
		`LC_ADDR_STS: rd_data = {16'h0000, sts_view};
		`LC_ADDR_IRQ_STS: rd_data = {30'h0000_0000, irq_view};
		`LC_ADDR_IRQ_MASK: rd_data = {30'h0000_0000, irq_mask_reg};
		default: rd_err = 1'b1;
		endcase
	end

	always @* begin
		case (wr_addr)
		`LC_ADDR_CTL, `LC_ADDR_STS, `LC_ADDR_IRQ_STS,
		`LC_ADDR_IRQ_MASK: wr_err = `LC_ZERO1;
		default: wr_err = 1'b1;
		endcase
	end
endmodule // link_control_upper_fields

// ### inc/link_ctl_consts.vh
// link control upper fields: offsets, field positions, reset values
// assumes inclusion by bare name from every design file of this block
//
// Behaviour
// - while extra_sync_ordered_sets is one the port asks for extra ordered sets on L0s exit and in Recovery.
// - clock_pm_enable is read-only and always reads zero.
// - autonomous_width_disable is read-only and always reads zero.
// - the port narrows link width by itself only to correct unreliable operation.
// - autonomous_width_disable never affects width changes from the reconfiguration mechanism.
// - with bandwidth_mgmt_irq_enable set, setting bandwidth_mgmt_status raises an interrupt.
// - with autonomous_bw_irq_enable set, setting autonomous_bw_status raises an interrupt.
// - without bandwidth_notify_capable both interrupt enables are held at zero.
// - on the upstream port both enables are held at zero; downstream they are read-write, reset zero.
// - bandwidth_mgmt_status sets on retrain completion or reliability change without DL_Down; write one clears.
`ifndef LINK_CTL_CONSTS_VH
`define LINK_CTL_CONSTS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define LC_ADDR_CTL 4'h0
`define LC_ADDR_STS 4'h4
`define LC_ADDR_IRQ_STS 4'h8
`define LC_ADDR_IRQ_MASK 4'hc

// ----------------------------------------
// field positions
// ----------------------------------------
`define LC_BIT_EXTRA_SYNC_ORDERED_SETS 7
`define LC_BIT_CLKPM 8
`define LC_BIT_AWD 9
`define LC_BIT_BWM_EN 10
`define LC_BIT_ABW_EN 11
`define LC_BIT_BWM_STS 14
`define LC_BIT_ABW_STS 15
`define LC_IRQ_BWM 0
`define LC_IRQ_ABW 1

// ----------------------------------------
// reset values and answers
// ----------------------------------------
`define LC_ZERO1 1'h0
`define LC_ZERO2 2'h0
`define LC_ZERO32 32'h0000_0000
`define LC_RESP_OKAY 2'h0
`define LC_RESP_SLVERR 2'h2

`endif

// ### hdl/lc_sticky_bit.v
// one sticky status flag, set by hardware, cleared by writing one
// assumes set and clear are single-cycle pulses on sys_clk_i
`include "link_ctl_consts.vh"
module lc_sticky_bit (
	// clock and reset
	input wire sys_clk_i,
	input wire nrst_i,
	input wire clk_en_i,
	// control
	input wire enable_i,
	input wire set_i,
	input wire clear_i,
	// state
	output reg flag_o
);
	// set beats a simultaneous clear so no event is lost
	always @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			flag_o <= `LC_ZERO1;
		end else if (clk_en_i) begin
			if (!enable_i)
				flag_o <= `LC_ZERO1;
			else if (set_i)
				flag_o <= 1'b1;
			else if (clear_i)
				flag_o <= `LC_ZERO1;
		end
	end
endmodule // lc_sticky_bit

// ### hdl/lc_axil_slave.v
// axi4-lite slave front end: takes one write and one read at a time
// assumes a master that holds valid and payload until ready
`include "link_ctl_consts.vh"
module lc_axil_slave #(
	parameter AW = 4
) (
	// clock and reset
	input wire sys_clk_i,
	input wire nrst_i,
	input wire clk_en_i,
	// axi write
	input wire [AW-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi read
	input wire [AW-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// register side
	output wire wr_stb_o,
	output wire [AW-1:0] wr_addr_o,
	output wire [31:0] wr_data_o,
	output wire [3:0] wr_strb_o,
	input wire wr_err_i,
	output wire [AW-1:0] rd_addr_o,
	input wire [31:0] rd_data_i,
	input wire rd_err_i
);
	reg aw_full_reg;
	reg w_full_reg;
	reg [AW-1:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;
	wire rd_stb;

	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
	assign wr_stb_o = aw_full_reg && w_full_reg && clk_en_i;
	assign wr_addr_o = awaddr_reg;
	assign wr_data_o = wdata_reg;
	assign wr_strb_o = wstrb_reg;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_stb = s_axi_arvalid && s_axi_arready && clk_en_i;
	assign rd_addr_o = s_axi_araddr;

	// ----------------------------------------
	// write path
	// ----------------------------------------
	always @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_full_reg <= `LC_ZERO1;
			w_full_reg <= `LC_ZERO1;
			awaddr_reg <= {AW{1'b0}};
			wdata_reg <= `LC_ZERO32;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= `LC_ZERO1;
			s_axi_bresp <= `LC_RESP_OKAY;
		end else if (clk_en_i) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_stb_o) begin
				aw_full_reg <= `LC_ZERO1;
				w_full_reg <= `LC_ZERO1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err_i ? `LC_RESP_SLVERR : `LC_RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= `LC_ZERO1;
			end
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always @(posedge sys_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_rvalid <= `LC_ZERO1;
			s_axi_rdata <= `LC_ZERO32;
			s_axi_rresp <= `LC_RESP_OKAY;
		end else if (clk_en_i) begin
			if (rd_stb) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_err_i ? `LC_ZERO32 : rd_data_i;
				s_axi_rresp <= rd_err_i ? `LC_RESP_SLVERR : `LC_RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= `LC_ZERO1;
			end
		end
	end
endmodule // lc_axil_slave

// ### dv/lc_monitor.sv
// checker for link_control_upper_fields, watching top ports only
// assumes single clock domain and async active-low reset
module lc_monitor (
	// clock and reset
	input logic sys_clk_i,
	input logic nrst_i,
	input logic clk_en_i,
	// bus handshakes
	input logic s_axi_wvalid,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [31:0] s_axi_rdata,
	// link side
	input logic bandwidth_notify_capable_i,
	input logic retrain_done_i,
	input logic reliability_change_i,
	input logic autonomous_change_i,
	input logic extra_sync_ordered_sets_o,
	input logic autonomous_width_disable_o,
	input logic reliability_width_allow_o,
	input logic link_irq_o,
	input logic irq_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);

	// a register write lands one or two edges after data is offered
	sequence wr_recent;
		$past(s_axi_wvalid) || $past(s_axi_wvalid, 2);
	endsequence

	extra_sync_ordered_sets_by_write_a: assert property (
		$changed(extra_sync_ordered_sets_o) |-> wr_recent)
		else $error("sync bit moved without a write");
	awd_zero_a: assert property (
		autonomous_width_disable_o == 1'b0)
		else $error("width disable not zero");
	rel_allow_a: assert property (
		reliability_width_allow_o == reliability_change_i)
		else $error("width change not tied to reliability");
	irq_needs_cap_a: assert property (
		link_irq_o |-> bandwidth_notify_capable_i)
		else $error("link irq without capability");
	irq_rise_cause_a: assert property (
		$rose(link_irq_o) |-> wr_recent or
		$past(retrain_done_i || reliability_change_i || autonomous_change_i)
		or $rose(bandwidth_notify_capable_i))
		else $error("link irq rose without cause");
	irq_fall_cause_a: assert property (
		$fell(link_irq_o) |-> wr_recent or !bandwidth_notify_capable_i)
		else $error("link irq fell without clear");
	irq_out_cause_a: assert property (
		$rose(irq_o) |-> wr_recent or $past(link_irq_o))
		else $error("irq rose without cause");
	read_answer_a: assert property (
		s_axi_arvalid && s_axi_arready && clk_en_i |=> s_axi_rvalid)
		else $error("read answer late");
	read_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	resp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");

	cover property ($rose(link_irq_o));
	cover property ($rose(irq_o));
	cover property (s_axi_bvalid && !s_axi_bready);
endmodule // lc_monitor

bind link_control_upper_fields lc_monitor u_mon (.sys_clk_i, .nrst_i,
	.clk_en_i, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .bandwidth_notify_capable_i, .retrain_done_i,
	.reliability_change_i, .autonomous_change_i, .extra_sync_ordered_sets_o,
	.autonomous_width_disable_o, .reliability_width_allow_o, .link_irq_o,
	.irq_o);

// ### dv/link_control_upper_fields_tb_top.sv
// self-checking bench for link_control_upper_fields over axi4-lite
// assumes downstream instance, aw of 4 bits, seed fixed at 25
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	n_fail++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module link_control_upper_fields_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic sys_clk_i, nrst_i, clk_en_i, s_axi_awvalid, s_axi_wvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, e, m, x;
	logic bandwidth_notify_capable_i, retrain_done_i, dl_down_i;
	logic reliability_change_i, autonomous_change_i, link_irq_o, irq_o;
	logic extra_sync_ordered_sets_o, autonomous_width_disable_o;
	logic reliability_width_allow_o;
	int n_fail, samples_checked, seed, i;

	link_control_upper_fields uut (.sys_clk_i, .nrst_i, .clk_en_i,
		.s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.bandwidth_notify_capable_i, .retrain_done_i, .dl_down_i,
		.reliability_change_i, .autonomous_change_i,
		.extra_sync_ordered_sets_o, .autonomous_width_disable_o,
		.reliability_width_allow_o, .link_irq_o, .irq_o);

	// ----------------------------------------
	// bus master and expectations
	// ----------------------------------------
	// handshakes read at the rising edge, before the slave's updates land
	task automatic xfer(input bit w, input logic [3:0] a,
		input logic [31:0] dv);
		bit ah, wh, dh;
		@(posedge sys_clk_i);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= dv;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'($urandom % 2);
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'($urandom % 2);
		end
		do begin
			@(posedge sys_clk_i);
			ah = w ? s_axi_awvalid && s_axi_awready :
				s_axi_arvalid && s_axi_arready;
			wh = s_axi_wvalid && s_axi_wready;
			dh = w ? s_axi_bvalid && s_axi_bready :
				s_axi_rvalid && s_axi_rready;
			resp = w ? s_axi_bresp : s_axi_rresp;
			rdat = s_axi_rdata;
			if (ah && w) s_axi_awvalid <= 1'b0;
			if (ah && !w) s_axi_arvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
			if (!dh && w) s_axi_bready <= 1'b1;
			if (!dh && !w) s_axi_rready <= 1'b1;
		end while (!dh);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask

	task automatic rc(input logic [3:0] a, input logic [31:0] ex);
		xfer(1'b0, a, 32'h0000_0000);
		`CHK("rdata", ex, rdat)
	endtask

	function automatic logic [31:0] ctl_exp(logic [31:0] v, bit c);
		return v & (c ? 32'h0000_0c80 : 32'h0000_0080);
	endfunction

	// event 0 retrain, 1 reliability, 2 autonomous, 3 retrain in dl_down
	function automatic logic [1:0] ev_exp(int k, logic [1:0] en);
		return (k < 2) ? {1'b0, en[0]} : (k == 2) ? {en[1], 1'b0} : 2'h0;
	endfunction

	task automatic results();
		$display("checks %0d errors %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// clock, watchdog, tests
	// ----------------------------------------
	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		results();
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, retrain_done_i, dl_down_i} = 3'h0;
		{reliability_change_i, autonomous_change_i} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 14'h0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		clk_en_i = 1'b1;
		bandwidth_notify_capable_i = 1'b1;
		nrst_i = 1'b0;
		seed = $urandom(25);
		repeat (10) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		rc(4'h0, 32'h0000_0000);
		rc(4'h4, 32'h0000_0000);
		rc(4'h8, 32'h0000_0000);
		for (i = 0; i < 8; i++) begin
			d = (i == 0) ? 32'hffff_ffff : $urandom;
			xfer(1'b1, 4'h0, d);
			`CHK("bresp", 2'h0, resp)
			`CHK("extra_sync_ordered_sets", d[7], extra_sync_ordered_sets_o)
			`CHK("awd", 1'b0, autonomous_width_disable_o)
			rc(4'h0, ctl_exp(d, 1'b1));
		end
		bandwidth_notify_capable_i <= 1'b0;
		rc(4'h0, ctl_exp(d, 1'b0));
		bandwidth_notify_capable_i <= 1'b1;
		for (int k = 0; k < 12; k++) begin
			i = k % 4;
			e = (k < 4) ? 2'h3 : 2'($urandom);
			m = 2'($urandom);
			xfer(1'b1, 4'h0, {20'h0, e, 10'h000});
			xfer(1'b1, 4'hc, {30'h0, m});
			{autonomous_change_i, reliability_change_i, retrain_done_i} <=
				(i == 3) ? 3'h1 : 3'h1 << i;
			dl_down_i <= (i == 3);
			@(posedge sys_clk_i);
			`CHK("allow", i == 1, reliability_width_allow_o)
			{autonomous_change_i, reliability_change_i, retrain_done_i} <= 3'h0;
			dl_down_i <= 1'b0;
			@(posedge sys_clk_i);
			x = ev_exp(i, e);
			`CHK("link_irq", |x, link_irq_o)
			rc(4'h4, (i < 2) ? 32'h0000_4000 : (i == 2) ? 32'h0000_8000 : 0);
			rc(4'h8, {30'h0, x});
			`CHK("irq", |(x & m), irq_o)
			xfer(1'b1, 4'h4, 32'h0000_c000);
			`CHK("link_irq clr", 1'b0, link_irq_o)
			xfer(1'b1, 4'h8, 32'h0000_0003);
			`CHK("irq clr", 1'b0, irq_o)
			rc(4'h4, 32'h0000_0000);
		end
		// frozen clock enable must swallow an event
		clk_en_i <= 1'b0;
		retrain_done_i <= 1'b1;
		@(posedge sys_clk_i);
		retrain_done_i <= 1'b0;
		clk_en_i <= 1'b1;
		rc(4'h4, 32'h0000_0000);
		// mid-run reset returns written fields to zero
		xfer(1'b1, 4'h0, 32'h0000_0c80);
		`CHK("extra_sync_ordered_sets set", 1'b1, extra_sync_ordered_sets_o)
		nrst_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		nrst_i <= 1'b1;
		`CHK("extra_sync_ordered_sets rst", 1'b0, extra_sync_ordered_sets_o)
		rc(4'h0, 32'h0000_0000);
		rc(4'hc, 32'h0000_0000);
		rc(4'h2, 32'h0000_0000);
		`CHK("unmapped", 2'h2, resp)
		results();
	end
endmodule // link_control_upper_fields_tb_top
